//--- mbc_top.sv
// Purpose: misc bus configuration register of the link function and the logic it steers
// Assumes: rst is the global reset; bus resets and power changes never reach it
// Notes:   config port is a simple strobed read/write port already decoded to function 1
//
// What this block does
// - register at F0h of function 1, resets to 0000_0800h
// - upper sixteen bits read zero, hold nothing
// - bit 15 mirrored to capabilities bit 15 cold wake support
// - bits 14..12 drive high, mid, low power level inputs
// - bit 11 read-only, always one
// - bit 10 set makes wake ignore the master interrupt enable
// - bit 10 also shows as link vendor id bit 26
// - bits 9..8 choose command for reads over two data phases
// - one or two phase reads always use plain memory read
// - bits 9..8 loaded from serial memory word 12 bits 1..0
// - bit 7 selects pm revision code 010b or 011b
// - bits 6 and 5 read zero, not writable
// - bit 4 set replaces target abort with indeterminate data
// - access to stopped link clock aborts, or returns FFh
// - bit 3 routes gp pins three, two to two-wire, pins high-z
// - bit 2 bypasses link clock gating, test only
// - bit 1 bypasses bus clock gating, test only
// - bit 0 keeps bus clock running, else stop allowed on pin six
// - only global reset clears the register
`timescale 1ns/1ps
`include "mbc_consts.svh"
module mbc_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata_q,
  output logic             cfg_rvalid_q,
  input  wire logic        eeprom_present,
  input  wire logic        eeprom_wr,
  input  wire logic [7:0]  eeprom_word,
  input  wire logic [15:0] eeprom_data,
  output logic             cold_wake_support_q,
  output logic [2:0]       pm_revision_field_q,
  output logic             power_level_in_high_q,
  output logic             power_level_in_mid_q,
  output logic             power_level_in_low_q,
  output logic             vendor_id_bit26_q,
  input  wire logic        irq_unmasked_any,
  input  wire logic        master_irq_enable,
  output logic             wake_event_q,
  input  wire logic        mst_rd_req,
  input  wire logic [7:0]  mst_rd_phases,
  output logic             mst_rd_cmd_valid_q,
  output logic [3:0]       mst_rd_cmd_q,
  input  wire logic        tgt_acc,
  input  wire logic        tgt_abort_cond,
  input  wire logic        link_acc,
  input  wire logic        link_clk_running,
  output logic             tgt_abort_q,
  output logic             tgt_fill_valid_q,
  output logic [31:0]      tgt_fill_data_q,
  input  wire logic        gp_three_o,
  input  wire logic        gp_three_oe,
  input  wire logic        gp_two_o,
  input  wire logic        gp_two_oe,
  output logic             gp_three_i_q,
  output logic             gp_two_i_q,
  input  wire logic        gp_pin_three_i,
  output logic             gp_pin_three_o_q,
  output logic             gp_pin_three_oe_q,
  input  wire logic        gp_pin_two_i,
  output logic             gp_pin_two_o_q,
  output logic             gp_pin_two_oe_q,
  input  wire logic        twowire_scl_i,
  output logic             twowire_scl_o_q,
  output logic             twowire_scl_oe_q,
  input  wire logic        twowire_sda_i,
  output logic             twowire_sda_o_q,
  output logic             twowire_sda_oe_q,
  input  wire logic        link_clk_gate_req,
  input  wire logic        bus_clk_gate_req,
  output logic             link_clk_en_q,
  output logic             bus_clk_en_q,
  input  wire logic        pin_six_is_clkrun,
  output logic             bus_clk_keep_q,
  output logic             bus_clk_stop_ok_q
);
  import mbc_pkg::*;

  logic [15:0] reg_q;
  logic [15:0] wmask;
  logic        hit;
  logic [31:0] read_val;
  logic [1:0]  sync_three_q;
  logic [1:0]  sync_two_q;
  logic [1:0]  sync_scl_q;
  logic [1:0]  sync_sda_q;
  logic        abort_cause;

  mbc_cmd_if cmd_c ();

  assign hit = (cfg_addr == `MBC_CFG_OFFSET);
  assign wmask = {{8{cfg_be[1]}}, {8{cfg_be[0]}}} & `MBC_WR_MASK;

  // storage; byte lanes gate whole fields since none straddles a lane
  // a config write beats a serial memory load in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_q <= 16'(`MBC_RESET_VALUE);
    end else if (cfg_wr && hit) begin
      reg_q <= (reg_q & ~wmask) | (cfg_wdata[15:0] & wmask);
    end else if (eeprom_present && eeprom_wr && eeprom_word == `MBC_EEPROM_WORD) begin
      reg_q[`MBC_BIT_RDCMD_HI:`MBC_BIT_RDCMD_LO] <= eeprom_data[1:0];
    end
  end

  always_comb begin
    read_val = 32'h0000_0000;
    read_val[15:0] = reg_q & `MBC_WR_MASK;
    // bit 11 rebuilt on every read so the stored copy never matters
    // constant one
    read_val[`MBC_BIT_REV23] = 1'b1;
    read_val[6:5] = 2'b00;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_rdata_q  <= 32'h0000_0000;
      cfg_rvalid_q <= 1'b0;
    end else begin
      cfg_rvalid_q <= cfg_rd && hit;
      cfg_rdata_q  <= (cfg_rd && hit) ? read_val : 32'h0000_0000;
    end
  end

  // capability and core strap outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cold_wake_support_q   <= 1'b0;
      pm_revision_field_q   <= `MBC_PM_REV_OLD;
      power_level_in_high_q <= 1'b0;
      power_level_in_mid_q  <= 1'b0;
      power_level_in_low_q  <= 1'b0;
      vendor_id_bit26_q     <= 1'b0;
    end else begin
      cold_wake_support_q   <= reg_q[`MBC_BIT_COLD_WAKE];
      pm_revision_field_q   <= reg_q[`MBC_BIT_PM_REV] ? `MBC_PM_REV_NEW : `MBC_PM_REV_OLD;
      power_level_in_high_q <= reg_q[`MBC_BIT_PWR_HI];
      power_level_in_mid_q  <= reg_q[`MBC_BIT_PWR_HI-1];
      power_level_in_low_q  <= reg_q[`MBC_BIT_PWR_LO];
      vendor_id_bit26_q     <= reg_q[`MBC_BIT_WAKE_IGN];
    end
  end

  // wake generation
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wake_event_q <= 1'b0;
    end else begin
      wake_event_q <= irq_unmasked_any && (master_irq_enable || reg_q[`MBC_BIT_WAKE_IGN]);
    end
  end

  // master read command
  assign cmd_c.sel    = mbc_rdsel_t'(reg_q[`MBC_BIT_RDCMD_HI:`MBC_BIT_RDCMD_LO]);
  assign cmd_c.req    = mst_rd_req;
  assign cmd_c.phases = mst_rd_phases;

  mbc_cmd_sel u_cmd_sel (
    .clk_sys (clk_sys),
    .rst     (rst),
    .c       (cmd_c)
  );

  assign mst_rd_cmd_valid_q = cmd_c.cmd_valid;
  assign mst_rd_cmd_q       = cmd_c.cmd;

  // target abort handling; the fill word is what a stopped link clock returns,
  // other suppressed aborts reuse it as the indeterminate data
  assign abort_cause = tgt_acc && (tgt_abort_cond || (link_acc && !link_clk_running));

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tgt_abort_q      <= 1'b0;
      tgt_fill_valid_q <= 1'b0;
      tgt_fill_data_q  <= 32'h0000_0000;
    end else begin
      tgt_abort_q      <= abort_cause && !reg_q[`MBC_BIT_NO_ABORT];
      tgt_fill_valid_q <= abort_cause && reg_q[`MBC_BIT_NO_ABORT];
      tgt_fill_data_q  <= `MBC_ABORT_FILL;
    end
  end

  // pin inputs come from outside the clock domain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync_three_q <= 2'b00;
      sync_two_q   <= 2'b00;
      sync_scl_q   <= 2'b00;
      sync_sda_q   <= 2'b00;
    end else begin
      sync_three_q <= {sync_three_q[0], gp_pin_three_i};
      sync_two_q   <= {sync_two_q[0], gp_pin_two_i};
      sync_scl_q   <= {sync_scl_q[0], twowire_scl_i};
      sync_sda_q   <= {sync_sda_q[0], twowire_sda_i};
    end
  end

  // gp pins float while routed to the two-wire lines
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gp_pin_three_o_q  <= 1'b0;
      gp_pin_three_oe_q <= 1'b0;
      gp_pin_two_o_q    <= 1'b0;
      gp_pin_two_oe_q   <= 1'b0;
    end else if (reg_q[`MBC_BIT_TWOWIRE]) begin
      gp_pin_three_o_q  <= 1'b0;
      gp_pin_three_oe_q <= 1'b0;
      gp_pin_two_o_q    <= 1'b0;
      gp_pin_two_oe_q   <= 1'b0;
    end else begin
      gp_pin_three_o_q  <= gp_three_o;
      gp_pin_three_oe_q <= gp_three_oe;
      gp_pin_two_o_q    <= gp_two_o;
      gp_pin_two_oe_q   <= gp_two_oe;
    end
  end

  // two-wire lines carry the gpio drive only while routed, else released
  // an open-drain user holds o low and toggles oe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      twowire_scl_o_q  <= 1'b0;
      twowire_scl_oe_q <= 1'b0;
      twowire_sda_o_q  <= 1'b0;
      twowire_sda_oe_q <= 1'b0;
    end else if (reg_q[`MBC_BIT_TWOWIRE]) begin
      twowire_scl_o_q  <= gp_three_o;
      twowire_scl_oe_q <= gp_three_oe;
      twowire_sda_o_q  <= gp_two_o;
      twowire_sda_oe_q <= gp_two_oe;
    end else begin
      twowire_scl_o_q  <= 1'b0;
      twowire_scl_oe_q <= 1'b0;
      twowire_sda_o_q  <= 1'b0;
      twowire_sda_oe_q <= 1'b0;
    end
  end

  // internal inputs read whichever lines the gpios own
  // both paths are already synchronised, so a switch costs one odd sample at most
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gp_three_i_q <= 1'b0;
      gp_two_i_q   <= 1'b0;
    end else if (reg_q[`MBC_BIT_TWOWIRE]) begin
      gp_three_i_q <= sync_scl_q[1];
      gp_two_i_q   <= sync_sda_q[1];
    end else begin
      gp_three_i_q <= sync_three_q[1];
      gp_two_i_q   <= sync_two_q[1];
    end
  end

  // gate enables run from reset so both clocks start; the bypass bits are
  // test hooks only and simply hold the enable on
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link_clk_en_q <= 1'b1;
      bus_clk_en_q  <= 1'b1;
    end else begin
      link_clk_en_q <= link_clk_gate_req || reg_q[`MBC_BIT_LINK_BYP];
      bus_clk_en_q  <= bus_clk_gate_req || reg_q[`MBC_BIT_BUS_BYP];
    end
  end

  // keep the bus clock, or offer a stop when pin six carries the run request
  // with pin six used otherwise the stop is never offered
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bus_clk_keep_q    <= 1'b0;
      bus_clk_stop_ok_q <= 1'b0;
    end else begin
      bus_clk_keep_q    <= reg_q[`MBC_BIT_KEEP_CLK];
      bus_clk_stop_ok_q <= !reg_q[`MBC_BIT_KEEP_CLK] && pin_six_is_clkrun;
    end
  end
endmodule : mbc_top

//--- mbc_consts.svh
// Purpose: offsets, bit positions, reset values and codes of the misc bus config register
// Assumes: included by bare name
// Notes:   definitions only
`ifndef MBC_CONSTS_SVH
`define MBC_CONSTS_SVH

`define MBC_CFG_OFFSET      8'hf0
`define MBC_RESET_VALUE     32'h0000_0800
`define MBC_WR_MASK         16'hf79f
`define MBC_BIT_COLD_WAKE   15
`define MBC_BIT_PWR_HI      14
`define MBC_BIT_PWR_LO      12
`define MBC_BIT_REV23       11
`define MBC_BIT_WAKE_IGN    10
`define MBC_BIT_RDCMD_HI    9
`define MBC_BIT_RDCMD_LO    8
`define MBC_BIT_PM_REV      7
`define MBC_BIT_NO_ABORT    4
`define MBC_BIT_TWOWIRE     3
`define MBC_BIT_LINK_BYP    2
`define MBC_BIT_BUS_BYP     1
`define MBC_BIT_KEEP_CLK    0
`define MBC_EEPROM_WORD     8'h0c
`define MBC_PM_REV_OLD      3'h2
`define MBC_PM_REV_NEW      3'h3
`define MBC_ABORT_FILL      32'h0000_00ff
`define MBC_CMD_MEM_READ    4'h6
`define MBC_CMD_READ_MULT   4'hc
`define MBC_CMD_READ_LINE   4'he
`define MBC_SHORT_PHASES    2

`endif

//--- mbc_pkg.sv
// Purpose: shared types of the misc bus config block
// Assumes: constants live in mbc_consts.svh
// Notes:   none
package mbc_pkg;
  typedef enum logic [1:0] {
    MBC_RD_LINE,
    MBC_RD_PLAIN,
    MBC_RD_MULT,
    MBC_RD_RSVD
  } mbc_rdsel_t;
endpackage : mbc_pkg

//--- mbc_cmd_if.sv
// Purpose: carrier between top and read command selector
// Assumes: one clock
// Notes:   none
`timescale 1ns/1ps
interface mbc_cmd_if;
  import mbc_pkg::*;
  mbc_rdsel_t  sel;
  logic        req;
  logic [7:0]  phases;
  logic        cmd_valid;
  logic [3:0]  cmd;
  modport regs (output sel, output req, output phases, input cmd_valid, input cmd);
  modport sel_m (input sel, input req, input phases, output cmd_valid, output cmd);
endinterface : mbc_cmd_if

//--- mbc_cmd_sel.sv
// Purpose: picks the bus command for a master read
// Assumes: request fields stable in the request cycle
// Notes:   result registered, one cycle after the request
`timescale 1ns/1ps
`include "mbc_consts.svh"
module mbc_cmd_sel (
  input wire logic clk_sys,
  input wire logic rst,
  mbc_cmd_if.sel_m c
);
  import mbc_pkg::*;

  logic [3:0] cmd_d;

  always_comb begin
    cmd_d = `MBC_CMD_READ_LINE;
    if (c.phases <= 8'(`MBC_SHORT_PHASES)) begin
      cmd_d = `MBC_CMD_MEM_READ;
    end else begin
      unique case (c.sel)
        MBC_RD_LINE:  cmd_d = `MBC_CMD_READ_LINE;
        MBC_RD_PLAIN: cmd_d = `MBC_CMD_MEM_READ;
        MBC_RD_MULT:  cmd_d = `MBC_CMD_READ_MULT;
        MBC_RD_RSVD:  cmd_d = `MBC_CMD_READ_LINE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      c.cmd_valid <= 1'b0;
      c.cmd       <= 4'h0;
    end else begin
      c.cmd_valid <= c.req;
      if (c.req) begin
        c.cmd <= cmd_d;
      end
    end
  end
endmodule : mbc_cmd_sel

//--- mbc_top_props.sv
// Purpose: concurrent checks on the misc bus config register ports
// Assumes: derived outputs and read data both reflect the register one cycle late
// Notes:   bound to mbc_top
`timescale 1ns/1ps
module mbc_top_props (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        cfg_rd,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic        cfg_rvalid_q,
  input wire logic        cold_wake_support_q,
  input wire logic [2:0]  pm_revision_field_q,
  input wire logic        power_level_in_high_q,
  input wire logic        vendor_id_bit26_q,
  input wire logic        irq_unmasked_any,
  input wire logic        master_irq_enable,
  input wire logic        wake_event_q,
  input wire logic        mst_rd_req,
  input wire logic [7:0]  mst_rd_phases,
  input wire logic        mst_rd_cmd_valid_q,
  input wire logic [3:0]  mst_rd_cmd_q,
  input wire logic        tgt_acc,
  input wire logic        tgt_abort_cond,
  input wire logic        tgt_abort_q,
  input wire logic        tgt_fill_valid_q,
  input wire logic [31:0] tgt_fill_data_q,
  input wire logic        gp_pin_three_oe_q,
  input wire logic        twowire_scl_oe_q,
  input wire logic        link_clk_gate_req,
  input wire logic        link_clk_en_q,
  input wire logic        bus_clk_keep_q,
  input wire logic        bus_clk_stop_ok_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  hit_read_a: assert property (cfg_rd && cfg_addr == 8'hf0 |=> cfg_rvalid_q)
    else $error("register read gave no valid");
  upper_zero_a: assert property (cfg_rvalid_q |-> cfg_rdata_q[31:16] == 16'h0000)
    else $error("upper half not zero");
  fixed_bits_a: assert property (cfg_rvalid_q |-> cfg_rdata_q[11] && !cfg_rdata_q[6] && !cfg_rdata_q[5])
    else $error("fixed bits wrong");
  mirror_out_a: assert property (cfg_rvalid_q |-> cold_wake_support_q == cfg_rdata_q[15]
    && power_level_in_high_q == cfg_rdata_q[14] && vendor_id_bit26_q == cfg_rdata_q[10])
    else $error("derived outputs disagree with register");
  pm_rev_a: assert property (cfg_rvalid_q |-> pm_revision_field_q == (cfg_rdata_q[7] ? 3'h3 : 3'h2))
    else $error("pm revision code wrong");
  short_read_a: assert property (mst_rd_req && mst_rd_phases <= 8'h02
    |=> mst_rd_cmd_valid_q && mst_rd_cmd_q == 4'h6) else $error("short read command wrong");
  wake_on_a: assert property (irq_unmasked_any && master_irq_enable |=> wake_event_q)
    else $error("wake missing");
  wake_cause_a: assert property (wake_event_q |-> $past(irq_unmasked_any))
    else $error("wake without interrupt");
  abort_kind_a: assert property (tgt_acc && tgt_abort_cond |=> tgt_abort_q != tgt_fill_valid_q)
    else $error("abort answer wrong");
  fill_data_a: assert property (tgt_fill_valid_q |-> tgt_fill_data_q == 32'h0000_00ff)
    else $error("fill data wrong");
  pin_hiz_a: assert property (twowire_scl_oe_q |-> !gp_pin_three_oe_q)
    else $error("pin driven while routed");
  link_en_a: assert property (link_clk_gate_req |=> link_clk_en_q)
    else $error("link clock not enabled");
  keep_clk_a: assert property (bus_clk_stop_ok_q |-> !bus_clk_keep_q)
    else $error("stop allowed while kept");
  cover property (tgt_fill_valid_q);
  cover property (mst_rd_cmd_valid_q && mst_rd_cmd_q == 4'hc);
  cover property (twowire_scl_oe_q);
endmodule : mbc_top_props

bind mbc_top mbc_top_props u_props (.*);

//--- mbc_tb.sv
// Purpose: self-checking bench of the misc bus config register
// Assumes: one clock, synchronous reset
// Notes:   one task per scenario
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, eeprom_present = 0, eeprom_wr = 0;
  logic [7:0] cfg_addr = 8'hf0, eeprom_word = 8'h00, mst_rd_phases = 8'h00;
  logic [3:0] cfg_be = 4'hf;
  logic [31:0] cfg_wdata = 32'h0000_0000, v;
  logic [15:0] eeprom_data = 16'h0000;
  logic irq_unmasked_any = 0, master_irq_enable = 0, mst_rd_req = 0, tgt_acc = 0;
  logic tgt_abort_cond = 0, link_acc = 0, link_clk_running = 1, gp_three_o = 0, gp_three_oe = 0;
  logic gp_two_o = 0, gp_two_oe = 0, gp_pin_three_i = 0, gp_pin_two_i = 0, twowire_scl_i = 1;
  logic twowire_sda_i = 1, link_clk_gate_req = 0, bus_clk_gate_req = 0, pin_six_is_clkrun = 1;
  logic [31:0] cfg_rdata_q, tgt_fill_data_q;
  logic [2:0] pm_revision_field_q;
  logic [3:0] mst_rd_cmd_q;
  logic cfg_rvalid_q, cold_wake_support_q, power_level_in_high_q, power_level_in_mid_q;
  logic power_level_in_low_q, vendor_id_bit26_q, wake_event_q, mst_rd_cmd_valid_q, tgt_abort_q;
  logic tgt_fill_valid_q, gp_three_i_q, gp_two_i_q, gp_pin_three_o_q, gp_pin_three_oe_q;
  logic gp_pin_two_o_q, gp_pin_two_oe_q, twowire_scl_o_q, twowire_scl_oe_q, twowire_sda_o_q;
  logic twowire_sda_oe_q, link_clk_en_q, bus_clk_en_q, bus_clk_keep_q, bus_clk_stop_ok_q;
  int miscompares = 0, checked = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  mbc_top dut (.*);
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task results;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // whole run is under two hundred cycles; a hang stops here
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      results();
    end
  end
  task wr(input logic [31:0] d, input logic [3:0] be = 4'hf);
    @(posedge clk_sys); cfg_wr <= 1; cfg_wdata <= d; cfg_be <= be;
    @(posedge clk_sys); cfg_wr <= 0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys); cfg_rd <= 1; cfg_addr <= a;
    @(posedge clk_sys); cfg_rd <= 0; cfg_addr <= 8'hf0;
    #1;
    chk("rvalid", cfg_rvalid_q, a == 8'hf0);
    v = cfg_rdata_q;
  endtask : rd
  task t_regs;
    rd(8'hf0); chk("reset value", v, 32'h0000_0800);
    rd(8'hf4);
    wr(32'hffff_ffff); rd(8'hf0); chk("all ones", v, 32'h0000_ff9f);
    chk("derived", {cold_wake_support_q, power_level_in_high_q, power_level_in_mid_q,
      power_level_in_low_q, vendor_id_bit26_q, pm_revision_field_q}, 8'h fb);
    wr(32'h0000_0000, 4'h1); rd(8'hf0); chk("low byte", v, 32'h0000_ff00);
    wr(32'h0000_0000); rd(8'hf0); chk("cleared", v, 32'h0000_0800);
    chk("clock keep", {bus_clk_keep_q, bus_clk_stop_ok_q, pm_revision_field_q}, 5'h0a);
  endtask : t_regs
  task t_cmd;
    logic [3:0] exp [4];
    exp = '{4'he, 4'h6, 4'hc, 4'he};
    for (int s = 0; s < 4; s++) begin
      wr({22'h0, s[1:0], 8'h00});
      for (int p = 1; p < 4; p++) begin
        @(posedge clk_sys); mst_rd_req <= 1; mst_rd_phases <= p[7:0];
        @(posedge clk_sys); mst_rd_req <= 0;
        #1;
        chk("cmd", {mst_rd_cmd_valid_q, mst_rd_cmd_q}, {1'b1, p < 3 ? 4'h6 : exp[s]});
      end
    end
  endtask : t_cmd
  task t_eeprom;
    wr(32'h0000_0000);
    @(posedge clk_sys); eeprom_present <= 1; eeprom_wr <= 1; eeprom_word <= 8'h0c;
    eeprom_data <= 16'h0002;
    @(posedge clk_sys); eeprom_wr <= 0;
    rd(8'hf0); chk("serial load", v, 32'h0000_0a00);
    @(posedge clk_sys);
    eeprom_present <= 0;
    eeprom_wr <= 1;
    eeprom_data <= 16'h0001;
    @(posedge clk_sys);
    eeprom_wr <= 0;
    rd(8'hf0); chk("no serial memory", v, 32'h0000_0a00);
  endtask : t_eeprom
  task t_abort;
    for (int b = 0; b < 2; b++) begin
      wr({27'h0, b[0], 4'h0});
      // cause: plain abort, stopped link clock, link access with clock running
      for (int k = 0; k < 3; k++) begin
        @(posedge clk_sys);
        tgt_acc <= 1;
        tgt_abort_cond <= (k == 0);
        link_acc <= (k != 0);
        link_clk_running <= (k == 2);
        @(posedge clk_sys);
        tgt_acc <= 0;
        tgt_abort_cond <= 0;
        #1;
        chk("abort", {tgt_abort_q, tgt_fill_valid_q}, {b == 0 && k < 2, b == 1 && k < 2});
        if (b == 1 && k < 2) chk("fill", tgt_fill_data_q, 32'h0000_00ff);
      end
    end
    wr(32'h0000_0000);
  endtask : t_abort
  task t_misc;
    @(posedge clk_sys);
    irq_unmasked_any <= 1;
    wr(32'h0000_0000); chk("wake masked", wake_event_q, 0);
    wr(32'h0000_0400); chk("wake ignore", {wake_event_q, vendor_id_bit26_q}, 2'b11);
    @(posedge clk_sys);
    master_irq_enable <= 1;
    wr(32'h0000_0000); chk("wake enabled", wake_event_q, 1);
    @(posedge clk_sys);
    irq_unmasked_any <= 0;
    wr(32'h0000_0000); chk("wake idle", wake_event_q, 0);
    @(posedge clk_sys);
    gp_three_o <= 1;
    gp_three_oe <= 1;
    gp_two_o <= 1;
    gp_two_oe <= 1;
    twowire_sda_i <= 0;
    wr(32'h0000_0008);
    chk("routed", {gp_pin_three_oe_q, gp_pin_two_oe_q, gp_pin_three_o_q, gp_pin_two_o_q,
      twowire_scl_o_q, twowire_scl_oe_q, twowire_sda_o_q, twowire_sda_oe_q, gp_three_i_q,
      gp_two_i_q}, 10'h03e);
    @(posedge clk_sys);
    gp_pin_three_i <= 1;
    wr(32'h0000_0000);
    chk("unrouted", {gp_pin_three_oe_q, gp_pin_three_o_q, gp_pin_two_oe_q, gp_pin_two_o_q,
      twowire_scl_oe_q, twowire_sda_oe_q, gp_three_i_q, gp_two_i_q}, 8'hf2);
    wr(32'h0000_0006); chk("bypass", {link_clk_en_q, bus_clk_en_q}, 2'b11);
    @(posedge clk_sys);
    link_clk_gate_req <= 1;
    wr(32'h0000_0000); chk("gated", {link_clk_en_q, bus_clk_en_q}, 2'b10);
    @(posedge clk_sys);
    link_clk_gate_req <= 0;
    bus_clk_gate_req <= 1;
    wr(32'h0000_0000); chk("bus gated", {link_clk_en_q, bus_clk_en_q}, 2'b01);
    wr(32'h0000_0001); chk("keep clock", {bus_clk_keep_q, bus_clk_stop_ok_q}, 2'b10);
    @(posedge clk_sys);
    pin_six_is_clkrun <= 0;
    wr(32'h0000_0000); chk("no stop pin", {bus_clk_keep_q, bus_clk_stop_ok_q}, 2'b00);
  endtask : t_misc
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 0;
    t_regs();
    t_cmd();
    t_eeprom();
    t_abort();
    t_misc();
    results();
  end
endmodule : testbench
